/* File: design/csw_int_status.sv */
// Purpose: latched event flags and operating status registers
// Assumes: byte register port on clk; status inputs synchronous to clk
// Notes:   reads are registered, data valid one cycle after rdEn
`timescale 1ns/1ps
`include "csw_cfg.svh"

module csw_int_status
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [6:0]   addr,
  input  wire logic         wrEn,
  input  wire logic [7:0]   wrData,
  input  wire logic         rdEn,
  output logic [7:0]        rdData,
  input  wire csw_pkg::csw_events_s  events,
  input  wire csw_pkg::csw_loss_s    lossInd,
  input  wire csw_pkg::csw_loss_en_s lossEn,
  input  wire logic         readbackLoopSelect,
  input  wire logic [2:0]   firstLoopFreqTop,
  input  wire logic [2:0]   secondLoopFreqTop,
  input  wire logic         firstLoopSoftLimitAlarm,
  input  wire logic         secondLoopSoftLimitAlarm
);
  import csw_pkg::*;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire logic selLow   = (addr == `CSW_OFF_FLAGS_LOW);
  wire logic selMid   = (addr == `CSW_OFF_FLAGS_MID);
  wire logic selFreq  = (addr == `CSW_OFF_FREQ_TOP);
  wire logic selHigh  = (addr == `CSW_OFF_FLAGS_HIGH);
  wire logic selState = (addr == `CSW_OFF_LOOP_STATE);
  wire logic wrLow    = wrEn & selLow;
  wire logic wrMid    = wrEn & selMid;
  wire logic wrHigh   = wrEn & selHigh;
  // test location two has no storage; software keeps it at zero

  // ---------------------------------------------------------------
  // event history
  // ---------------------------------------------------------------
  logic [3:0] primaryValid_reg;
  logic       standbyValid_reg;
  logic [2:0] loopState_reg;
  logic       syncAlarm_reg;
  logic [1:0] missCount_reg;
  logic [1:0] missCount_next;
  logic       secondLock_reg;
  logic       secondLock_next;
  logic [7:0] rdData_reg;

  wire logic [3:0] primaryChange = events.primaryValid ^ primaryValid_reg;
  wire logic standbyChange = events.standbyValid ^ standbyValid_reg;
  wire logic stateChange   = events.firstLoopState != loopState_reg;
  // alarm flag fires on the rising edge of the monitor alarm
  wire logic syncRise      = events.syncAlarm & ~syncAlarm_reg;
  wire logic refTracked =
    (events.firstLoopState != `CSW_STATE_FREERUN) &&
    (events.firstLoopState != `CSW_STATE_HOLDOVER);
  // count consecutive missing cycles; no wait for invalidation
  assign missCount_next = !refTracked || !events.refCycleMissing ? 2'h0 :
    (missCount_reg == `CSW_MISS_LIMIT ? missCount_reg
                                      : missCount_reg + 2'h1);
  wire logic mainLost = refTracked && events.refCycleMissing &&
    (missCount_reg == `CSW_MISS_LIMIT - 2'h1);

  // ---------------------------------------------------------------
  // sticky flags
  // ---------------------------------------------------------------
  logic [3:0] primaryFlag;
  logic       standbyFlag;
  logic       mainLostFlag;
  logic       modeFlag;
  logic       syncFlag;

  // power-up values follow the register defaults; bits without a flag
  // are dropped at read time, so only the flag bits are taken here
  localparam logic [7:0] LOW_RESET  = `CSW_RST_FLAGS_LOW;
  localparam logic [7:0] MID_RESET  = `CSW_RST_FLAGS_MID;
  localparam logic [7:0] HIGH_RESET = `CSW_RST_FLAGS_HIGH;
  // every flag below lets a same-cycle event beat the clear

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : gPrim
      csw_w1c_flag #(.RESET_VALUE(LOW_RESET[`CSW_LOW_LSB + gi])) uFlag (
        .clk        (clk),
        .rst        (rst),
        .setEvent   (primaryChange[gi]),
        .clearWrite (wrLow & wrData[`CSW_LOW_LSB + gi]),
        .flagOut    (primaryFlag[gi])
      );
    end
  endgenerate

  csw_w1c_flag #(.RESET_VALUE(MID_RESET[`CSW_BIT_STANDBY])) uStandby (
    .clk        (clk),
    .rst        (rst),
    .setEvent   (standbyChange),
    .clearWrite (wrMid & wrData[`CSW_BIT_STANDBY]),
    .flagOut    (standbyFlag)
  );

  csw_w1c_flag #(.RESET_VALUE(MID_RESET[`CSW_BIT_MAINLOST])) uMainLost (
    .clk        (clk),
    .rst        (rst),
    .setEvent   (mainLost),
    .clearWrite (wrMid & wrData[`CSW_BIT_MAINLOST]),
    .flagOut    (mainLostFlag)
  );

  csw_w1c_flag #(.RESET_VALUE(MID_RESET[`CSW_BIT_MODECHG])) uMode (
    .clk        (clk),
    .rst        (rst),
    .setEvent   (stateChange),
    .clearWrite (wrMid & wrData[`CSW_BIT_MODECHG]),
    .flagOut    (modeFlag)
  );

  csw_w1c_flag #(.RESET_VALUE(HIGH_RESET[`CSW_BIT_SYNCINT])) uSync (
    .clk        (clk),
    .rst        (rst),
    .setEvent   (syncRise),
    .clearWrite (wrHigh & wrData[`CSW_BIT_SYNCINT]),
    .flagOut    (syncFlag)
  );

  // ---------------------------------------------------------------
  // second loop lock
  // ---------------------------------------------------------------
  // enables are shared with the first loop's loss detectors
  wire logic secondLossSeen =
    (lossInd.fineLoss       & lossEn.fineEn)       |
    (lossInd.coarseLoss     & lossEn.coarseEn)     |
    (lossInd.noActivityLoss & lossEn.noActivityEn) |
    (lossInd.atFreqLimit    & lossEn.freqLimitEn);
  // once low, stays low while coarse detection is enabled; dropping
  // the coarse enable lets the bit follow the live indicators again
  assign secondLock_next = secondLossSeen ? 1'b0 :
    (lossEn.coarseEn ? secondLock_reg : 1'b1);

  // ---------------------------------------------------------------
  // history and read registers
  // ---------------------------------------------------------------
  wire logic [7:0] lowByte   = {2'h0, primaryFlag, 2'h0};
  wire logic [7:0] midByte   = {modeFlag, mainLostFlag, 5'h00, standbyFlag};
  wire logic [7:0] highByte  = {syncFlag, 7'h00};
  wire logic [2:0] freqTop   = readbackLoopSelect ? secondLoopFreqTop
                                                  : firstLoopFreqTop;
  wire logic [7:0] stateByte = {syncAlarm_reg, secondLock_reg,
    firstLoopSoftLimitAlarm, secondLoopSoftLimitAlarm, 1'b0,
    loopState_reg};
  // selects are one-hot, so an and-or tree replaces a priority chain;
  // test location two and unmapped addresses fall through to zero
  wire logic [7:0] rdMux =
    ({8{selLow}}   & lowByte)          |
    ({8{selMid}}   & midByte)          |
    ({8{selFreq}}  & {5'h00, freqTop}) |
    ({8{selHigh}}  & highByte)         |
    ({8{selState}} & stateByte);

  // ---------------------------------------------------------------
  // clocked state
  // ---------------------------------------------------------------
  // input history feeds the change detectors above
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      primaryValid_reg <= 4'h0;
      standbyValid_reg <= 1'b0;
      loopState_reg    <= `CSW_RST_STATE;
      syncAlarm_reg    <= 1'b0;
    end
    else
    begin
      primaryValid_reg <= events.primaryValid;
      standbyValid_reg <= events.standbyValid;
      loopState_reg    <= events.firstLoopState;
      syncAlarm_reg    <= events.syncAlarm;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      missCount_reg  <= 2'h0;
      secondLock_reg <= 1'b0;
    end
    else
    begin
      missCount_reg  <= missCount_next;
      secondLock_reg <= secondLock_next;
    end
  end

  // read data holds between reads so a slow master may fetch it late
  always_ff @(posedge clk)
  begin
    if (rst)
      rdData_reg <= 8'h00;
    else if (rdEn)
      rdData_reg <= rdMux;
  end

  assign rdData = rdData_reg;
endmodule // csw_int_status

/* File: design/csw_cfg.svh */
// Purpose: constants for the clock-switch interrupt status block
// Assumes: byte-wide register port, addresses as printed
// Notes:   offsets, field positions, reset values
`ifndef CSW_CFG_SVH
`define CSW_CFG_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CSW_OFF_TEST_TWO   7'h04
`define CSW_OFF_FLAGS_LOW  7'h05
`define CSW_OFF_FLAGS_MID  7'h06
`define CSW_OFF_FREQ_TOP   7'h07
`define CSW_OFF_FLAGS_HIGH 7'h08
`define CSW_OFF_LOOP_STATE 7'h09
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CSW_RST_FLAGS_LOW  8'hff
`define CSW_RST_FLAGS_MID  8'h3f
`define CSW_RST_FLAGS_HIGH 8'h10
`define CSW_RST_STATE      3'h1
// ---------------------------------------------------------------
// field positions, miss limit and state codes
// ---------------------------------------------------------------
`define CSW_BIT_STANDBY    0
`define CSW_BIT_MAINLOST   6
`define CSW_BIT_MODECHG    7
`define CSW_BIT_SYNCINT    7
`define CSW_LOW_LSB        2
`define CSW_MISS_LIMIT     2'h2
`define CSW_STATE_FREERUN  3'h1
`define CSW_STATE_HOLDOVER 3'h2
`endif

/* File: design/csw_pkg.sv */
// Purpose: shared types of the clock-switch interrupt status block
// Assumes: included constants header
// Notes:   carriers for events and live status
package csw_pkg;
  typedef struct packed {
    logic [3:0] primaryValid;
    logic       standbyValid;
    logic [2:0] firstLoopState;
    logic       refCycleMissing;
    logic       syncAlarm;
  } csw_events_s;

  typedef struct packed {
    logic fineLoss;
    logic coarseLoss;
    logic noActivityLoss;
    logic atFreqLimit;
  } csw_loss_s;

  typedef struct packed {
    logic fineEn;
    logic coarseEn;
    logic noActivityEn;
    logic freqLimitEn;
  } csw_loss_en_s;
endpackage

/* File: design/csw_w1c_flag.sv */
// Purpose: one sticky flag, set by hardware, cleared by writing one
// Assumes: single clock, synchronous reset
// Notes:   set outranks clear
`timescale 1ns/1ps
module csw_w1c_flag #(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic setEvent,
  input  wire logic clearWrite,
  output logic      flagOut
);
  logic flag_reg;
  logic flag_next;

  // a clear in the same cycle as an event loses to the event
  assign flag_next = setEvent | (flag_reg & ~clearWrite);
  assign flagOut = flag_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
      flag_reg <= RESET_VALUE;
    else
      flag_reg <= flag_next;
  end
endmodule // csw_w1c_flag

/* File: testbench/csw_int_status_properties.sv */
// Purpose: port assertions for csw_int_status
// Assumes: rdData answers on the edge that takes rdEn
// Notes:   one clock domain; bound after the module
`timescale 1ns/1ps
module csw_int_status_properties
  import csw_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic [6:0]            addr,
  input wire logic                  wrEn,
  input wire logic [7:0]            wrData,
  input wire logic                  rdEn,
  input wire logic [7:0]            rdData,
  input wire csw_pkg::csw_events_s  events,
  input wire csw_pkg::csw_loss_s    lossInd,
  input wire csw_pkg::csw_loss_en_s lossEn,
  input wire logic                  readbackLoopSelect,
  input wire logic [2:0]            firstLoopFreqTop,
  input wire logic [2:0]            secondLoopFreqTop
);
  // ------------------------------------------------
  // decode and assertions
  // ------------------------------------------------
  wire rd6 = rdEn && addr == 7'h06;
  wire rd8 = rdEn && addr == 7'h08;
  wire rd9 = rdEn && addr == 7'h09;
  wire wr8c = wrEn && addr == 7'h08 && wrData[7];
  wire anyLoss = |(lossInd & lossEn);
  // freerun and holdover never count missing cycles
  wire missOk = events.refCycleMissing && events.firstLoopState != 3'h1
    && events.firstLoopState != 3'h2;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  prim_flag_a:
    assert property ($changed(events.primaryValid[0]) ##1 rdEn
      && addr == 7'h05 |=> rdData[2]) else $error("primary flag missing");
  standby_flag_a:
    assert property ($changed(events.standbyValid) ##1 rd6 |=> rdData[0])
    else $error("standby flag missing");
  mode_flag_a:
    assert property ($changed(events.firstLoopState) ##1 rd6 |=> rdData[7])
    else $error("mode flag missing");
  ref_lost_a:
    assert property (missOk [*2] ##1 rd6 |=> rdData[6])
    else $error("reference lost flag missing");
  sync_set_a:
    assert property ($rose(events.syncAlarm) ##1 rd8 |=> rdData[7])
    else $error("sync flag missing");
  sync_clear_a:
    assert property (wr8c && !$rose(events.syncAlarm) ##1 rd8 |=> !rdData[7])
    else $error("sync flag not cleared");
  freq_select_a:
    assert property (rdEn && addr == 7'h07 |=> rdData == {5'h00,
      $past(readbackLoopSelect) ? $past(secondLoopFreqTop)
      : $past(firstLoopFreqTop)}) else $error("frequency bits wrong");
  sync_live_a:
    assert property (rd9 && !$past(rst) |=> rdData[7] ==
      $past(events.syncAlarm, 2)) else $error("live sync bit wrong");
  lock_drop_a:
    assert property (anyLoss ##1 rd9 |=> !rdData[6])
    else $error("lock bit high after loss");
  unmapped_a:
    assert property (rdEn && !(addr inside {[7'h05:7'h09]}) |=>
      rdData == 8'h00) else $error("unmapped read not zero");
  cover property (missOk [*2]);
  cover property (wr8c && $rose(events.syncAlarm));
  cover property (rd9 ##1 rdData[6]);
  cover property (events.firstLoopState == 3'h2 && events.refCycleMissing);
endmodule // csw_int_status_properties

bind csw_int_status csw_int_status_properties chk_u (.clk, .rst, .addr,
  .wrEn, .wrData, .rdEn, .rdData, .events, .lossInd, .lossEn,
  .readbackLoopSelect, .firstLoopFreqTop, .secondLoopFreqTop);

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for csw_int_status
// Assumes: inputs change on the falling edge
// Notes:   reads queue their expected byte
`timescale 1ns/1ps
module tb_top;
  import csw_pkg::*;
  // ------------------------------------------------
  // stimulus, monitor and verdict
  // ------------------------------------------------
  localparam int EVB[7] = '{6, 7, 8, 9, 5, 2, 0};
  localparam logic [6:0] RGA[7] = '{5, 5, 5, 5, 6, 6, 8};
  localparam logic [7:0] MSK[7] = '{4, 8, 16, 32, 1, 128, 128};
  logic clk = 1'b0, rst = 1'b1, wrEn = 1'b0, rdEn = 1'b0, sel = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] wrData = 8'h00, rdData, expQ[$];
  logic [2:0] fA = 3'h0, fB = 3'h0;
  logic sA = 1'b0, sB = 1'b0, seen = 1'b0;
  csw_events_s events = csw_events_s'(10'h004);
  csw_loss_s lossInd = csw_loss_s'(4'h0);
  csw_loss_en_s lossEn = csw_loss_en_s'(4'hf);
  int err_count = 0, checks_done = 0;
  always #4 clk = ~clk;
  csw_int_status dut_u (.clk(clk), .rst(rst), .addr(addr), .wrEn(wrEn),
    .wrData(wrData), .rdEn(rdEn), .rdData(rdData), .events(events),
    .lossInd(lossInd), .lossEn(lossEn), .readbackLoopSelect(sel),
    .firstLoopFreqTop(fA), .secondLoopFreqTop(fB),
    .firstLoopSoftLimitAlarm(sA), .secondLoopSoftLimitAlarm(sB));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // kind 1 writes d, kind 2 reads and expects d, kind 0 idles
  task automatic op(input int k, input logic [6:0] a, input logic [7:0] d);
    wrEn = (k == 1);
    rdEn = (k == 2);
    addr = a;
    wrData = d;
    if (k == 2)
      expQ.push_back(d);
    @(negedge clk);
  endtask
  always @(posedge clk)
    seen <= rdEn;
  always @(negedge clk)
    if (seen)
      check(rdData, expQ.pop_front());
  initial
  begin
    void'($urandom(32'h2552));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    op(2, 7'h05, 8'h3c);
    op(2, 7'h06, 8'h01);
    op(2, 7'h09, 8'h01);
    op(1, 7'h04, 8'h00);
    op(2, 7'h04, 8'h00);
    op(2, 7'h0a, 8'h00);
    op(1, 7'h05, 8'hff);
    op(1, 7'h06, 8'hff);
    op(1, 7'h08, 8'hff);
    // second pass flips the input validity bits back, so both
    // directions are seen; loop state and sync alarm toggle once only
    for (int i = 0; i < 12; i++)
    begin
      int j;
      j = i % 7;
      events = csw_events_s'(events ^ (10'h001 << EVB[j]));
      op(0, 7'h00, 8'h00);
      op(2, RGA[j], MSK[j]);
      op(1, RGA[j], 8'($urandom) & ~MSK[j]);
      op(2, RGA[j], MSK[j]);
      op(1, RGA[j], MSK[j]);
      op(2, RGA[j], 8'h00);
    end
    events.syncAlarm = 1'b0;
    op(0, 7'h00, 8'h00);
    events.syncAlarm = 1'b1;
    op(1, 7'h08, 8'h80);
    op(2, 7'h08, 8'h80);
    for (int n = 1; n < 3; n++)
    begin
      events.refCycleMissing = 1'b1;
      repeat (n) op(0, 7'h00, 8'h00);
      events.refCycleMissing = 1'b0;
      op(2, 7'h06, (n == 2) ? 8'h40 : 8'h00);
    end
    // holdover first, then freerun, which is left in place afterwards
    for (int s = 2; s > 0; s--)
    begin
      events.firstLoopState = 3'(s);
      op(1, 7'h06, 8'hff);
      events.refCycleMissing = 1'b1;
      repeat (2) op(0, 7'h00, 8'h00);
      events.refCycleMissing = 1'b0;
      op(2, 7'h06, 8'h80);
    end
    for (int i = 0; i < 8; i++)
    begin
      {sel, fA, fB} = 7'($urandom);
      op(2, 7'h07, {5'h00, sel ? fB : fA});
    end
    for (int i = 0; i < 4; i++)
    begin
      {sA, sB} = 2'(i);
      op(2, 7'h09, {2'b10, sA, sB, 4'h1});
    end
    lossEn = csw_loss_en_s'(4'h0);
    lossInd = csw_loss_s'(4'h1 << ($urandom % 4));
    op(0, 7'h00, 8'h00);
    op(2, 7'h09, 8'hf1);
    lossEn = csw_loss_en_s'(4'hf);
    op(0, 7'h00, 8'h00);
    lossInd = csw_loss_s'(4'h0);
    op(2, 7'h09, 8'hb1);
    op(2, 7'h09, 8'hb1);
    op(0, 7'h00, 8'h00);
    print_verdict();
  end
  // the sequence needs about 125 cycles; this leaves wide margin
  initial
  begin
    #20us;
    err_count++;
    print_verdict();
  end
endmodule // tb_top
